// [hw/fpdh_pkg.sv]
// fpdh_pkg: constants and types for the flash power-down and hold block
// assumes: a 20 MHz ref_clk; serial pins sampled by that clock
package fpdh_pkg;

    // ------------------------------------------------------------
    // opcodes and identifier
    // ------------------------------------------------------------
    localparam logic [7:0] FPDH_OP_POWER_DOWN = 8'hB9;
    localparam logic [7:0] FPDH_OP_RESUME = 8'hAB;
    localparam int FPDH_DUMMY_BYTES = 3;
    localparam int FPDH_ID_START_BITS = 8 + 8 * FPDH_DUMMY_BYTES;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int FPDH_CLK_HZ = 20000000;
    localparam int FPDH_ENTRY_TIME_NS = 1000;   // power_down_entry_time
    localparam int FPDH_EXIT_TIME_NS = 5000;    // power_down_exit_time
    localparam int FPDH_RESUME_ID_TIME_NS = 5000; // resume_to_identifier_time
    // longest times round down, never below one cycle
    localparam int FPDH_ENTRY_CYC_RAW = FPDH_ENTRY_TIME_NS / 50;
    localparam int FPDH_EXIT_CYC_RAW = FPDH_EXIT_TIME_NS / 50;
    localparam int FPDH_ENTRY_CYC =
        (FPDH_ENTRY_CYC_RAW < 1) ? 1 : FPDH_ENTRY_CYC_RAW;
    localparam int FPDH_EXIT_CYC =
        (FPDH_EXIT_CYC_RAW < 1) ? 1 : FPDH_EXIT_CYC_RAW;
    // cycles from a pin edge to a registered flag: three for sync and
    // edge finding, two for state and output registers, one spare
    localparam int FPDH_PIPE_CYC = 6;
    localparam int FPDH_ENTRY_LOAD = FPDH_ENTRY_CYC - FPDH_PIPE_CYC;
    localparam int FPDH_EXIT_LOAD = FPDH_EXIT_CYC - FPDH_PIPE_CYC;
    localparam int FPDH_TIMER_W = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic FPDH_PIN_IDLE = 1'b1;
    // sync reset levels {pause, si, sck, cs}: clock and data idle low
    localparam logic [3:0] FPDH_PIN_RST =
        {FPDH_PIN_IDLE, 1'b0, 1'b0, FPDH_PIN_IDLE};

    // power state
    typedef enum logic [1:0] {
        FPDH_STANDBY,
        FPDH_ENTERING,
        FPDH_POWERED_DOWN,
        FPDH_EXITING
    } fpdh_state_type;

endpackage : fpdh_pkg

// [hw/fpdh_sync_if.sv]
// fpdh_sync_if: synchronised pin levels and edges between modules
// assumes: one driver module (fpdh_pin_sync) and one reader (fpdh_ctrl)
`timescale 1ns/1ps
`default_nettype none

interface fpdh_sync_if;
    logic cs_active;    // chip select asserted
    logic sck_rise;     // one-cycle pulses on serial clock edges
    logic sck_fall;
    logic sck_level;
    logic si_level;
    logic pause_level;  // pause pin asserted (low on pin)
    logic cs_rise;      // chip select released

    modport src (output cs_active, sck_rise, sck_fall, sck_level,
                 si_level, pause_level, cs_rise);
    modport dst (input cs_active, sck_rise, sck_fall, sck_level,
                 si_level, pause_level, cs_rise);
endinterface : fpdh_sync_if

`default_nettype wire

// [hw/fpdh_pin_sync.sv]
// fpdh_pin_sync: two-flop synchronisers and edge finders for the pins
// assumes: pins are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none

module fpdh_pin_sync
    import fpdh_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic sck,
    input wire logic si,
    input wire logic pause_b,
    fpdh_sync_if.src sync
);

    // ------------------------------------------------------------
    // synchronisers: stage one feeds stage two only
    // ------------------------------------------------------------
    logic [3:0] meta_q;
    logic [3:0] stab_q;
    logic [1:0] prev_q;   // previous sck and cs levels
    wire logic [3:0] pins = {pause_b, si, sck, cs_b};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_q[g] <= FPDH_PIN_RST[g];
                    stab_q[g] <= FPDH_PIN_RST[g];
                end else begin
                    meta_q[g] <= pins[g];
                    stab_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    // edge history from the stable stage; idle levels, no false edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= FPDH_PIN_RST[1:0];
        end else begin
            prev_q <= {stab_q[1], stab_q[0]};
        end
    end

    assign sync.cs_active = ~stab_q[0];
    assign sync.cs_rise = stab_q[0] & ~prev_q[0];
    assign sync.sck_level = stab_q[1];
    assign sync.sck_rise = stab_q[1] & ~prev_q[1];
    assign sync.sck_fall = ~stab_q[1] & prev_q[1];
    assign sync.si_level = stab_q[2];
    assign sync.pause_level = ~stab_q[3];

endmodule : fpdh_pin_sync

`default_nettype wire

// [hw/fpdh_ctrl.sv]
// fpdh_ctrl: deep power-down, resume with identifier readout, and hold
// assumes: host drives cs_b, sck, si, pause_b; 20 MHz ref_clk samples them
// pins reach the core three cycles late through sync and edge finder
// power timers load short by that latency plus the registers,
// so both limits hold when measured from the select pin
// identifier readout runs in standby and in power-down alike
// in power-down only a resume frame may drive the output
// bit count wraps high so long readouts keep byte alignment
// a release while paused clears the latch even against a set
// pause pin only gates the serial side, never the timed program
// write protect is synced on its own and never paused
`timescale 1ns/1ps
`default_nettype none

module fpdh_ctrl
    import fpdh_pkg::*;
#(
    parameter logic [7:0] DEVICE_ID = 8'h5A  // arbitrary value
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic sck,
    input wire logic si,
    input wire logic pause_b,
    input wire logic write_protect_b,
    input wire logic quad_enable_bit,
    input wire logic program_busy,
    input wire logic write_enable_latch_set,
    output logic so_out,
    output logic so_oe,
    output logic powered_down,
    output logic standby,
    output logic paused,
    output logic write_enable_latch,
    output logic write_protect_level,
    output logic frame_aborted
);

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    fpdh_sync_if sync ();

    fpdh_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .cs_b(cs_b),
        .sck(sck),
        .si(si),
        .pause_b(pause_b),
        .sync(sync)
    );

    // write protect also passes two flops
    logic wp_meta_q;
    logic wp_stab_q;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    fpdh_state_type state_q, state_d;
    logic [7:0] opcode_q;
    logic [5:0] bit_cnt_q;      // bit count in frame, wraps high
    logic [2:0] id_bit_q;       // identifier bit pointer
    logic [FPDH_TIMER_W-1:0] timer_q;
    logic pause_q;
    logic wel_q;
    logic so_q;
    logic so_oe_q;
    logic abort_q;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // true when the captured opcode equals the wanted one
    function automatic logic op_is(input logic [7:0] op,
                                   input logic [7:0] want);
        return (op == want);
    endfunction : op_is

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // pause pin is a control only when quad mode is off
    wire logic pause_ctl = sync.pause_level & ~quad_enable_bit;
    wire logic sck_low = ~sync.sck_level;
    // pause state changes only in a clock-low phase, with select
    wire logic pause_set = sync.cs_active & pause_ctl & sck_low;
    wire logic pause_clr = ~pause_ctl & sck_low;
    wire logic shifting = sync.cs_active & ~pause_q;
    wire logic take_bit = shifting & sync.sck_rise;
    wire logic full_op = (bit_cnt_q >= 6'd8);
    wire logic aligned = (bit_cnt_q[2:0] == 3'h0);
    wire logic good_end = sync.cs_rise & full_op & aligned & ~pause_q;
    wire logic is_pd = op_is(opcode_q, FPDH_OP_POWER_DOWN);
    wire logic is_res = op_is(opcode_q, FPDH_OP_RESUME);
    // frame ends that move the power state
    wire logic pd_taken = good_end & is_pd & ~program_busy;
    wire logic res_taken = good_end & is_res;
    wire logic id_phase = is_res & (bit_cnt_q >= 6'(FPDH_ID_START_BITS));
    wire logic timer_done = (timer_q == '0);
    wire logic pause_abort = sync.cs_rise & pause_q;
    // output off outside shifting, and in power-down unless resuming
    wire logic in_pd = (state_q == FPDH_POWERED_DOWN);
    wire logic so_block = ~shifting | (in_pd & ~is_res);
    // timer loads, already short by the pin-to-flag latency
    wire logic [FPDH_TIMER_W-1:0] entry_load =
        FPDH_TIMER_W'(FPDH_ENTRY_LOAD);
    wire logic [FPDH_TIMER_W-1:0] exit_load =
        FPDH_TIMER_W'(FPDH_EXIT_LOAD);

    // next power state
    always_comb begin
        state_d = state_q;
        case (state_q)
            FPDH_STANDBY: begin
                // short or misaligned frames fall through
                if (pd_taken) begin
                    state_d = FPDH_ENTERING;
                end
            end
            FPDH_ENTERING: begin
                if (timer_done) begin
                    state_d = FPDH_POWERED_DOWN;
                end
            end
            FPDH_POWERED_DOWN: begin
                // only resume is recognised; others drop
                if (res_taken) begin
                    state_d = FPDH_EXITING;
                end
            end
            FPDH_EXITING: begin
                if (timer_done) begin
                    state_d = FPDH_STANDBY;
                end
            end
            default: state_d = FPDH_STANDBY;
        endcase
    end

    // ------------------------------------------------------------
    // power state and timer
    // ------------------------------------------------------------
    // timers count down once loaded and then rest at zero
    // reset lands in standby
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= FPDH_STANDBY;
            timer_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_d == FPDH_ENTERING && state_q != FPDH_ENTERING) begin
                timer_q <= entry_load;
            end else if (state_d == FPDH_EXITING &&
                         state_q != FPDH_EXITING) begin
                timer_q <= exit_load;
            end else if (!timer_done) begin
                timer_q <= timer_q - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // opcode shifter and bit counter
    // ------------------------------------------------------------
    // only first eight bits form the opcode; the rest count only
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            opcode_q <= 8'h00;
            bit_cnt_q <= 6'h00;
        end else if (!sync.cs_active) begin
            bit_cnt_q <= 6'h00;
        end else if (take_bit) begin
            if (!full_op) begin
                opcode_q <= {opcode_q[6:0], sync.si_level};
            end
            if (bit_cnt_q == 6'h3F) begin
                // back to 56 keeps byte alignment and the readout phase
                bit_cnt_q <= 6'h38;
            end else begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // hold pause
    // ------------------------------------------------------------
    // pause affects only the serial side; program_busy untouched
    // select going away clears it at once
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pause_q <= 1'b0;
        end else if (!sync.cs_active) begin
            pause_q <= 1'b0;
        end else if (pause_set) begin
            pause_q <= 1'b1;
        end else if (pause_q && pause_clr) begin
            pause_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // identifier output
    // ------------------------------------------------------------
    // shifts on falling clock, msb first, wraps forever
    // data holds while blocked; only the enable drops
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            id_bit_q <= 3'h7;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else if (so_block) begin
            so_oe_q <= 1'b0;
            if (!sync.cs_active) begin
                id_bit_q <= 3'h7;
            end
        end else if (sync.sck_fall && id_phase) begin
            so_q <= DEVICE_ID[id_bit_q];
            so_oe_q <= 1'b1;
            id_bit_q <= id_bit_q - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // write enable latch, abort flag, protect pin
    // ------------------------------------------------------------
    // set wins unless the frame is being aborted by a paused release
    // protect pin keeps its own sync, live even while paused
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wel_q <= 1'b0;
            abort_q <= 1'b0;
            wp_meta_q <= 1'b1;
            wp_stab_q <= 1'b1;
        end else begin
            wp_meta_q <= write_protect_b;
            wp_stab_q <= wp_meta_q; // sampled even while paused
            abort_q <= pause_abort;
            if (pause_abort) begin
                wel_q <= 1'b0;
            end else if (write_enable_latch_set) begin
                wel_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // registered status outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            powered_down <= 1'b0;
            standby <= 1'b0;
            paused <= 1'b0;
        end else begin
            // flags lag the state by this one register
            powered_down <= in_pd;
            // standby needs select high and nothing timed
            standby <= (state_q == FPDH_STANDBY) & ~sync.cs_active &
                       ~program_busy;
            paused <= pause_q;
        end
    end

    assign so_out = so_q;
    assign so_oe = so_oe_q;
    assign write_enable_latch = wel_q;
    assign write_protect_level = wp_stab_q;
    assign frame_aborted = abort_q;

endmodule : fpdh_ctrl

`default_nettype wire

// [verif/fpdh_ctrl_monitor.sv]
// fpdh_ctrl_monitor: port checks on fpdh_ctrl
// assumes: bound to fpdh_ctrl; pins pass a short sync
`timescale 1ns/1ps
`default_nettype none
module fpdh_ctrl_monitor
    import fpdh_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic sck,
    input wire logic si,
    input wire logic pause_b,
    input wire logic write_protect_b,
    input wire logic quad_enable_bit,
    input wire logic program_busy,
    input wire logic write_enable_latch_set,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic powered_down,
    input wire logic standby,
    input wire logic paused,
    input wire logic write_enable_latch,
    input wire logic write_protect_level,
    input wire logic frame_aborted
);
    // ----------
    // checks
    // ----------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // opcode seen on the pins, first eight bits of each frame
    logic sck_seen_q;
    logic [3:0] op_cnt_q;
    logic [7:0] op_seen_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_seen_q <= 1'b0;
            op_cnt_q <= 4'h0;
            op_seen_q <= 8'h00;
        end else begin
            sck_seen_q <= sck;
            if (cs_b) begin
                op_cnt_q <= 4'h0;
            end else if (sck && !sck_seen_q && op_cnt_q < 4'h8) begin
                op_cnt_q <= op_cnt_q + 4'h1;
                op_seen_q <= {op_seen_q[6:0], si};
            end
        end
    end
    property p_pd_float;
        powered_down && op_seen_q != FPDH_OP_RESUME |-> !so_oe;
    endproperty
    property p_busy; program_busy [*8] |-> !$rose(powered_down); endproperty
    property p_quad; $rose(paused) |-> !$past(quad_enable_bit); endproperty
    property p_start;
        $rose(paused) |-> !$past(cs_b, 2) && !$past(pause_b, 2);
    endproperty
    property p_hold;
        paused && !pause_b && !cs_b && !quad_enable_bit |=> paused;
    endproperty
    property p_end; paused && $rose(pause_b) && !sck |-> ##[1:6] !paused;
    endproperty
    property p_wp;
        paused && $fell(write_protect_b) |-> ##[1:4] !write_protect_level;
    endproperty
    property p_abort;
        paused && $rose(cs_b) |-> ##[1:6] frame_aborted && !write_enable_latch;
    endproperty
    a_pd_float: assert property (p_pd_float)
        else $error("output driven in power-down");
    a_busy: assert property (p_busy)
        else $error("power-down taken while busy");
    a_quad: assert property (p_quad)
        else $error("pause with quad enable set");
    a_start: assert property (p_start)
        else $error("pause without select and pause pin");
    a_hold: assert property (p_hold)
        else $error("pause dropped early");
    a_end: assert property (p_end)
        else $error("pause not ended");
    a_wp: assert property (p_wp)
        else $error("protect level frozen in pause");
    a_abort: assert property (p_abort)
        else $error("no abort on select release in pause");
    // main scenarios reached
    c_pd: cover property ($rose(powered_down));
    c_pause: cover property ($rose(paused));
    c_abort: cover property (frame_aborted);
    c_id: cover property ($rose(so_oe));
endmodule : fpdh_ctrl_monitor
bind fpdh_ctrl fpdh_ctrl_monitor i_fpdh_ctrl_monitor (.ref_clk, .rst_b,
    .cs_b, .sck, .si, .pause_b, .write_protect_b, .quad_enable_bit,
    .program_busy, .write_enable_latch_set, .so_out, .so_oe, .powered_down,
    .standby, .paused, .write_enable_latch, .write_protect_level,
    .frame_aborted);
`default_nettype wire

// [verif/fpdh_host.sv]
// fpdh_host: host serial controller model, mode 0, msb first
// assumes: 20 MHz ref_clk; sck period of 8 ref_clk cycles
`timescale 1ns/1ps
`default_nettype none
module fpdh_host (
    input wire logic ref_clk,
    input wire logic so_out,
    output logic cs_b,
    output logic sck,
    output logic si,
    output logic [7:0] got
);
    // ----------
    // frame tasks
    // ----------
    initial begin
        cs_b = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        got = 8'h00;
    end
    // select after a select-high gap
    task automatic select();
        repeat (8) @(posedge ref_clk);
        cs_b <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : select
    // reply taken late in the high phase to cover sync delay
    task automatic shift(input logic [7:0] tx, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            si <= tx[i];
            repeat (4) @(posedge ref_clk);
            sck <= 1'b1;
            repeat (4) @(posedge ref_clk);
            sck <= 1'b0;
            got <= {got[6:0], so_out};
        end
        @(posedge ref_clk);
    endtask : shift
    // release select; dropped data line shows the inverse
    task automatic deselect();
        repeat (4) @(posedge ref_clk);
        cs_b <= 1'b1;
        si <= ~si;
    endtask : deselect
endmodule : fpdh_host
`default_nettype wire

// [verif/fpdh_ctrl_test.sv]
// fpdh_ctrl_test: scenario bench for fpdh_ctrl
// assumes: package, host model and monitor compiled first
`timescale 1ns/1ps
`default_nettype none
module fpdh_ctrl_test
    import fpdh_pkg::*;
;
    localparam logic [7:0] DEV_ID = 8'hC3; // arbitrary value
    logic ref_clk, rst_b, cs_b, sck, si, pause_b, write_protect_b;
    logic quad_enable_bit, program_busy, write_enable_latch_set;
    logic so_out, so_oe, powered_down, standby, paused, frame_aborted;
    logic write_enable_latch, write_protect_level;
    logic [7:0] got;
    int failures = 0;
    int compares = 0;
    // ----------
    // instances and clock
    // ----------
    fpdh_ctrl #(.DEVICE_ID(DEV_ID)) i_fpdh_ctrl (.ref_clk, .rst_b, .cs_b,
        .sck, .si, .pause_b, .write_protect_b, .quad_enable_bit,
        .program_busy, .write_enable_latch_set, .so_out, .so_oe,
        .powered_down, .standby, .paused, .write_enable_latch,
        .write_protect_level, .frame_aborted);
    fpdh_host i_fpdh_host (.ref_clk, .so_out, .cs_b, .sck, .si, .got);
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ----------
    // helpers
    // ----------
    task automatic check(input string nm, input logic [7:0] e,
                         input logic [7:0] s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask : check
    // bounded wait for a flag, sampled mid-cycle
    task automatic wait_flag(input string nm, input logic e, input int n);
        logic v;
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            v = (nm == "standby") ? standby : powered_down;
            if (v === e) begin
                compares++;
                return;
            end
        end
        check(nm, {7'h00, e}, {7'h00, v});
        give_verdict();
    endtask : wait_flag
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : idle
    // opcode then up to eight trailing bits
    task automatic frame(input logic [7:0] op, input int n);
        i_fpdh_host.select();
        i_fpdh_host.shift(op, (n > 8) ? 8 : n);
        if (n > 8) begin
            i_fpdh_host.shift(8'h3C, n - 8);
        end
        i_fpdh_host.deselect();
    endtask : frame
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    // ----------
    // scenarios
    // ----------
    task automatic t_power();
        wait_flag("standby", 1'b1, 8);
        frame(FPDH_OP_POWER_DOWN, 7);
        frame(FPDH_OP_POWER_DOWN, 12);
        idle(40);
        check("powered_down", 8'h00, {7'h00, powered_down});
        frame(FPDH_OP_POWER_DOWN, 16);
        wait_flag("powered_down", 1'b1, FPDH_ENTRY_CYC);
        frame(8'h05, 16);
        frame(FPDH_OP_RESUME, 7);
        frame(FPDH_OP_RESUME, 12);
        idle(120);
        check("powered_down", 8'h01, {7'h00, powered_down});
    endtask : t_power
    task automatic t_resume_id();
        i_fpdh_host.select();
        for (int i = 0; i < FPDH_DUMMY_BYTES + 3; i++) begin
            i_fpdh_host.shift((i == 0) ? FPDH_OP_RESUME : 8'h00, 8);
            if (i > FPDH_DUMMY_BYTES) begin
                check("device id", DEV_ID, got);
                check("drive", 8'h01, {7'h00, so_oe});
            end
        end
        i_fpdh_host.deselect();
        wait_flag("standby", 1'b1, FPDH_EXIT_CYC);
        idle(100);
    endtask : t_resume_id
    task automatic t_busy();
        @(posedge ref_clk);
        program_busy <= 1'b1;
        frame(FPDH_OP_POWER_DOWN, 8);
        idle(40);
        check("powered_down", 8'h00, {7'h00, powered_down});
        @(posedge ref_clk);
        program_busy <= 1'b0;
        frame(FPDH_OP_POWER_DOWN, 8);
        wait_flag("powered_down", 1'b1, FPDH_ENTRY_CYC);
        frame(FPDH_OP_RESUME, 8);
        wait_flag("standby", 1'b1, FPDH_EXIT_CYC);
    endtask : t_busy
    // pause mid-frame, protect change, release, then abort
    task automatic t_pause(input logic qe);
        @(posedge ref_clk);
        write_enable_latch_set <= 1'b1;
        quad_enable_bit <= qe;
        @(posedge ref_clk);
        write_enable_latch_set <= 1'b0;
        i_fpdh_host.select();
        i_fpdh_host.shift(8'h06, 4);
        pause_b <= 1'b0;
        idle(8);
        check("paused", {7'h00, !qe}, {7'h00, paused});
        @(posedge ref_clk);
        write_protect_b <= 1'b0;
        idle(6);
        check("protect", 8'h00, {7'h00, write_protect_level});
        @(posedge ref_clk);
        pause_b <= 1'b1;
        write_protect_b <= 1'b1;
        idle(8);
        check("paused", 8'h00, {7'h00, paused});
        check("latch", 8'h01, {7'h00, write_enable_latch});
        @(posedge ref_clk);
        pause_b <= 1'b0;
        idle(8);
        i_fpdh_host.deselect();
        idle(3);
        check("abort", {7'h00, !qe}, {7'h00, frame_aborted});
        idle(6);
        check("latch", {7'h00, qe}, {7'h00, write_enable_latch});
        @(posedge ref_clk);
        pause_b <= 1'b1;
        idle(6);
    endtask : t_pause
    // ----------
    // main sequence
    // ----------
    initial begin
        rst_b = 1'b0;
        pause_b = 1'b1;
        write_protect_b = 1'b1;
        quad_enable_bit = 1'b0;
        program_busy = 1'b0;
        write_enable_latch_set = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_power();
        t_resume_id();
        t_busy();
        t_pause(1'b0);
        t_pause(1'b1);
        give_verdict();
    end
endmodule : fpdh_ctrl_test
`default_nettype wire
